//--- logic/otr_map.svh
// Offsets, field positions, reset values and timing figures of the oscillator training block.
// Assumes it is included by its bare name from the package and the top module.
`ifndef OTR_MAP_SVH
`define OTR_MAP_SVH
`define OTR_CFG_ADDR    4'h0
`define OTR_STAT_ADDR   4'h4
`define OTR_MASK_ADDR   4'h8
`define OTR_TRIM_ADDR   4'hc
`define OTR_CFG_W       14
`define OTR_CFG_RST     14'h0000
`define OTR_ST_FAULT    0
`define OTR_ST_ADJ      1
`define OTR_ST_MISS     2
`define OTR_ST_CFG      3
`define OTR_TRIM_W      8
`define OTR_TALLY_W     24
`define OTR_PER_W       6
`define OTR_FCNT_MAX    7'h7f
`define OTR_SPAN_US     16'd4000
`define OTR_CRM_MIN_US  16'd500
`define OTR_CRM_MAX_US  16'd4000
`define OTR_CLK_MHZ     100
`define OTR_SPAN_CYC    (`OTR_SPAN_US * `OTR_CLK_MHZ)
`endif

//--- logic/otr_pkg.sv
// Types of the oscillator training block.
// Assumes otr_map.svh sits on the include path.
`include "otr_map.svh"
package otr_pkg;
	typedef struct packed {
		logic [6:0] lim;
		logic [2:0] pdc;
		logic [1:0] crm;
		logic       rsel;
		logic       en;
	} otr_cfg_t;

	typedef struct packed {
		otr_cfg_t                   cfg;
		logic [3:0]                 status;
		logic [3:0]                 mask;
		logic [`OTR_TRIM_W-1:0]     trim;
		logic                       pend;
		logic                       pend_up;
		logic                       running;
		logic                       started;
		logic [`OTR_TALLY_W-1:0]    tally;
		logic [`OTR_PER_W-1:0]      periods;
		logic [6:0]                 fcnt;
		logic                       waitrq;
		logic [31:0]                rdata;
		logic                       irq;
	} otr_state_t;
endpackage : otr_pkg

//--- logic/otr_top.sv
// Oscillator training: measures master command periods against the local clock and steps trim.
// Assumes command and blocking-end pulses come from protocol logic on the same clock.
//
// The Avalon-MM register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "otr_map.svh"

// Notes on behaviour
// - With enable set, master command timing is checked against programmed intervals.
// - Commands per 4 ms span are derived from the active interval field.
// - Command-response training runs only for periods 500 us to 4 ms inclusive.
// - Periodic collection training runs every 4 ms span whenever enabled.
// - Local cycles are tallied across the derived number of command periods.
// - Trim may move only when the tally is inside the acceptance window.
// - Tally above expected plus dead band lowers the frequency target one step.
// - Tally below expected minus dead band raises the frequency target one step.
// - A new target is applied at the end of the closing command's blocking time.
// - Clearing enable after training began lets reset select choose the outcome.
// - Disabled with reset select clear, the last trim stays in effect.
// - Disabled with reset select set, the factory trim is restored.
// - Training works in every protocol mode of the device.
// - Up/down counter filters window misses; reaching the limit sets the fault flag.
// - The fault counter saturates at 127 and at 0.
// - A command-response period not dividing 4 ms raises the fault flag.
module otr_top #(
	parameter logic [`OTR_TALLY_W-1:0] EXPECT_TALLY = `OTR_TALLY_W'(`OTR_SPAN_CYC),
	parameter logic [`OTR_TALLY_W-1:0] ACCEPT_WIN   = 24'h009c40,
	parameter logic [`OTR_TALLY_W-1:0] DEAD_BAND    = 24'h000190,
	parameter logic [`OTR_TRIM_W-1:0]  TRIM_STEP    = 8'h01,
	parameter logic [`OTR_TRIM_W-1:0]  FACTORY_TRIM = 8'h80
) (
	input  wire logic                     sys_clk_i,
	input  wire logic                     rst_i,
	input  wire logic [3:0]               avs_address_i,
	input  wire logic                     avs_read_i,
	input  wire logic                     avs_write_i,
	input  wire logic [31:0]              avs_writedata_i,
	output logic [31:0]                   avs_readdata_o,
	output logic                          avs_waitrequest_o,
	input  wire logic                     cmd_seen_i,
	input  wire logic                     block_end_i,
	input  wire logic                     periodic_mode_i,
	output logic [`OTR_TRIM_W-1:0]        trim_target_o,
	output logic                          training_active_o,
	output logic                          irq_o
);
	import otr_pkg::*;

	otr_state_t                 s_r;
	otr_state_t                 s_nxt;
	logic [15:0]                per_us;
	logic [`OTR_PER_W-1:0]      n_per;
	logic                       whole;
	logic                       crm_range;
	logic                       crm_good;
	logic                       cfg_bad;
	logic                       trainable;
	logic                       close;
	logic                       in_win;
	logic                       go_down;
	logic                       go_up;
	logic                       apply_c;
	logic                       drop_c;
	logic                       rd_clr;
	logic [3:0]                 ev;

	function automatic logic [15:0] crm_us(input logic [1:0] c);
		case (c)
			2'h0: crm_us = 16'd250;
			2'h1: crm_us = 16'd500;
			2'h2: crm_us = 16'd1500;
			default: crm_us = 16'd4000;
		endcase
	endfunction : crm_us

	function automatic logic [15:0] pdc_us(input logic [2:0] c);
		case (c)
			3'h0: pdc_us = 16'd125;
			3'h1: pdc_us = 16'd250;
			3'h2: pdc_us = 16'd500;
			3'h3: pdc_us = 16'd1000;
			3'h4: pdc_us = 16'd2000;
			3'h5: pdc_us = 16'd4000;
			3'h6: pdc_us = 16'd200;
			default: pdc_us = 16'd400;
		endcase
	endfunction : pdc_us

	// Saturating trim step, so a runaway master cannot wrap the code
	function automatic logic [`OTR_TRIM_W-1:0] trim_move(input logic [`OTR_TRIM_W-1:0] t,
		input logic up);
		logic [`OTR_TRIM_W:0] v;
		if (up)
		begin
			v = {1'b0, t} + {1'b0, TRIM_STEP};
			trim_move = v[`OTR_TRIM_W] ? {`OTR_TRIM_W{1'b1}} : v[`OTR_TRIM_W-1:0];
		end
		else
		begin
			v = {1'b0, t} - {1'b0, TRIM_STEP};
			trim_move = v[`OTR_TRIM_W] ? {`OTR_TRIM_W{1'b0}} : v[`OTR_TRIM_W-1:0];
		end
	endfunction : trim_move

	assign per_us    = periodic_mode_i ? pdc_us(s_r.cfg.pdc) : crm_us(s_r.cfg.crm);
	assign n_per     = `OTR_PER_W'(`OTR_SPAN_US / per_us);
	assign whole     = (`OTR_SPAN_US % per_us) == 16'h0000;
	assign crm_range = (per_us >= `OTR_CRM_MIN_US) && (per_us <= `OTR_CRM_MAX_US);
	assign crm_good  = crm_range && whole;
	assign cfg_bad   = s_r.cfg.en && !periodic_mode_i && !crm_good;
	// periodic mode has no range gate
	assign trainable = s_r.cfg.en && (periodic_mode_i || crm_good);
	// span closes on the n-th command
	assign close     = s_r.running && cmd_seen_i
		&& (`OTR_PER_W'(s_r.periods + 1'b1) == n_per);
	assign in_win    = ({1'b0, s_r.tally} + {1'b0, ACCEPT_WIN} >= {1'b0, EXPECT_TALLY})
		&& ({1'b0, s_r.tally} <= {1'b0, EXPECT_TALLY} + {1'b0, ACCEPT_WIN});
	assign go_down   = {1'b0, s_r.tally} > {1'b0, EXPECT_TALLY} + {1'b0, DEAD_BAND};
	assign go_up     = {1'b0, s_r.tally} + {1'b0, DEAD_BAND} < {1'b0, EXPECT_TALLY};
	assign apply_c   = s_r.pend && block_end_i;
	assign drop_c    = s_r.started && !s_r.cfg.en;
	assign rd_clr    = avs_read_i && !s_r.waitrq && (avs_address_i == `OTR_STAT_ADDR);

	always_comb
	begin
		s_nxt = s_r;
		ev = 4'h0;
		s_nxt.waitrq = 1'b1;
		// One wait state: data is snapped on the first cycle, taken on the second
		if (avs_read_i && s_r.waitrq)
		begin
			s_nxt.waitrq = 1'b0;
			if (avs_address_i == `OTR_CFG_ADDR)
				s_nxt.rdata = {18'h00000, s_r.cfg};
			else if (avs_address_i == `OTR_STAT_ADDR)
				s_nxt.rdata = {28'h0000000, s_r.status};
			else if (avs_address_i == `OTR_MASK_ADDR)
				s_nxt.rdata = {28'h0000000, s_r.mask};
			else if (avs_address_i == `OTR_TRIM_ADDR)
				s_nxt.rdata = {17'h00000, s_r.fcnt, s_r.trim};
			else
				s_nxt.rdata = 32'h00000000;
		end
		if (avs_write_i && s_r.waitrq)
			s_nxt.waitrq = 1'b0;
		if (avs_write_i && !s_r.waitrq)
		begin
			if (avs_address_i == `OTR_CFG_ADDR)
				s_nxt.cfg = otr_cfg_t'(avs_writedata_i[`OTR_CFG_W-1:0]);
			else if (avs_address_i == `OTR_MASK_ADDR)
				s_nxt.mask = avs_writedata_i[3:0];
		end

		// apply pending target at blocking end
		if (apply_c)
		begin
			s_nxt.trim = trim_move(s_r.trim, s_r.pend_up);
			s_nxt.pend = 1'b0;
			ev[`OTR_ST_ADJ] = 1'b1;
		end

		if (!trainable)
			s_nxt.running = 1'b0;
		// command pulses from any protocol front end
		else if (cmd_seen_i && !s_r.running)
		begin
			s_nxt.running = 1'b1;
			s_nxt.started = 1'b1;
			// Start cycle counts too, so a span tallies n whole command gaps
			s_nxt.tally = `OTR_TALLY_W'(1);
			s_nxt.periods = '0;
		end
		else if (s_r.running)
		begin
			if (s_r.tally != {`OTR_TALLY_W{1'b1}})
				s_nxt.tally = s_r.tally + 1'b1;
			if (cmd_seen_i)
				s_nxt.periods = s_r.periods + 1'b1;
			if (close)
			begin
				// Closing command opens the next span, so no command period is lost
				s_nxt.tally = `OTR_TALLY_W'(1);
				s_nxt.periods = '0;
				if (in_win)
				begin
					if (s_r.fcnt != 7'h00)
						s_nxt.fcnt = s_r.fcnt - 1'b1;
					if (go_down)
					begin
						s_nxt.pend = 1'b1;
						s_nxt.pend_up = 1'b0;
					end
					else if (go_up)
					begin
						s_nxt.pend = 1'b1;
						s_nxt.pend_up = 1'b1;
					end
				end
				else
				begin
					if (s_r.fcnt != `OTR_FCNT_MAX)
						s_nxt.fcnt = s_r.fcnt + 1'b1;
					ev[`OTR_ST_MISS] = 1'b1;
				end
				// filtered fault on reaching the limit
				if ((s_r.cfg.lim != 7'h00) && (s_nxt.fcnt >= s_r.cfg.lim))
					ev[`OTR_ST_FAULT] = 1'b1;
			end
		end

		// period out of the 500 us to 4 ms range or not dividing the span
		if (cfg_bad)
		begin
			ev[`OTR_ST_FAULT] = 1'b1;
			ev[`OTR_ST_CFG] = 1'b1;
		end

		if (drop_c)
		begin
			s_nxt.started = 1'b0;
			s_nxt.pend = 1'b0;
			if (s_r.cfg.rsel)
				s_nxt.trim = FACTORY_TRIM;
			// otherwise the last trim is simply held
		end

		// Only bits that were reported get cleared; a new event always survives
		s_nxt.status = (s_r.status & ~(rd_clr ? s_r.rdata[3:0] : 4'h0)) | ev;
		s_nxt.irq = |(s_nxt.status & s_nxt.mask);
	end

	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			s_r <= '0;
			s_r.cfg <= `OTR_CFG_RST;
			s_r.trim <= FACTORY_TRIM;
			s_r.waitrq <= 1'b1;
		end
		else
			s_r <= s_nxt;
	end

	assign avs_readdata_o    = s_r.rdata;
	assign avs_waitrequest_o = s_r.waitrq;
	assign trim_target_o     = s_r.trim;
	assign training_active_o = s_r.running;
	assign irq_o             = s_r.irq;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	sequence apply_s;
		apply_c && s_r.cfg.en;
	endsequence
	sequence bad_crm_s;
		s_r.cfg.en && !periodic_mode_i && !crm_range;
	endsequence

	trim_only_apply_a:
	assert property ($changed(s_r.trim) |-> $past(apply_c) || $past(drop_c))
		else $error("trim changed outside blocking end or disable");
	apply_flags_a:
	assert property (apply_s |=> !s_r.pend && s_r.status[`OTR_ST_ADJ])
		else $error("pending trim not applied at blocking end");
	step_down_a:
	assert property (close && in_win && go_down && s_r.cfg.en |=> s_r.pend && !s_r.pend_up)
		else $error("high tally did not request a lower target");
	step_up_a:
	assert property (close && in_win && go_up && s_r.cfg.en |=> s_r.pend && s_r.pend_up)
		else $error("low tally did not request a higher target");
	no_adjust_out_a:
	assert property (close && !in_win && !s_r.pend |=> !s_r.pend)
		else $error("adjustment requested outside window");
	fault_ceiling_a:
	assert property (close && !in_win && s_r.fcnt == `OTR_FCNT_MAX |=> s_r.fcnt == `OTR_FCNT_MAX)
		else $error("fault counter wrapped past 127");
	fault_limit_a:
	assert property (close && !in_win && s_r.cfg.lim != 7'h00
		&& 7'(s_r.fcnt + 1'b1) == s_r.cfg.lim |=> s_r.status[`OTR_ST_FAULT])
		else $error("fault flag missed at counter limit");
	factory_restore_a:
	assert property (drop_c && s_r.cfg.rsel |=> s_r.trim == FACTORY_TRIM && !s_r.started)
		else $error("factory trim not restored");
	keep_trim_a:
	assert property (!s_r.cfg.en && !s_r.cfg.rsel && !s_r.pend ##1 !s_r.cfg.en |-> $stable(s_r.trim))
		else $error("trim moved while disabled");
	crm_range_a:
	assert property (bad_crm_s |=> !s_r.running)
		else $error("training ran with out-of-range period");
	span_fault_a:
	assert property (s_r.cfg.en && !periodic_mode_i && !whole |=> s_r.status[`OTR_ST_FAULT])
		else $error("non-divisor period did not raise fault");
	periodic_run_a:
	assert property (s_r.cfg.en && periodic_mode_i && cmd_seen_i |=> s_r.running)
		else $error("periodic training did not start");
endmodule : otr_top

//--- sim/oscillator_training_test.sv
// Self-checking bench for the oscillator training block.
// Assumes the design files and the master model are compiled first.
`timescale 1ns/1ps
module oscillator_training_test;
	localparam int E = 400;
	localparam int W = 40;
	localparam int D = 4;
	logic        sys_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [3:0]  avs_address_i = 4'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	logic        cmd_seen_i;
	logic        block_end_i;
	logic        periodic_mode_i = 1'b0;
	logic [7:0]  trim_target_o;
	logic        training_active_o;
	logic        irq_o;
	logic        run = 1'b0;
	logic [15:0] gap = 16'h0100;
	logic [31:0] q;
	int miscompares = 0;
	int comparisons = 0;
	int trim_m = 128;
	int fc = 0;
	int st_m = 0;
	int lim_m = 0;
	int r;
	// Columns: mode, crm, pdc, n, gap, spread, pulses, limit
	// Last row misses the window often enough to pin the fault counter at its ceiling
	int tb [9][8] = '{'{0,3,0,1,412,20,4,0}, '{0,3,0,1,370,25,3,0},
		'{0,3,0,1,401,1,2,0}, '{0,3,0,1,500,1,3,2}, '{0,1,0,8,53,1,9,0},
		'{1,3,0,32,13,1,33,0}, '{1,3,3,4,97,1,9,0}, '{1,3,6,20,21,1,21,0},
		'{0,3,0,1,13,1,130,100}};
	always #5 sys_clk_i = ~sys_clk_i;
	otr_top #(.EXPECT_TALLY(24'(E)), .ACCEPT_WIN(24'(W)), .DEAD_BAND(24'(D)),
		.TRIM_STEP(8'h01), .FACTORY_TRIM(8'h80)) dut_u (.sys_clk_i, .rst_i,
		.avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_readdata_o,
		.avs_waitrequest_o, .cmd_seen_i, .block_end_i, .periodic_mode_i,
		.trim_target_o, .training_active_o, .irq_o);
	otr_master_model mst_u (.sys_clk_i, .rst_i, .run_i(run), .gap_i(gap),
		.cmd_o(cmd_seen_i), .blk_o(block_end_i));
	task end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask : chk
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		for (i = 0; i < 20; i++)
		begin
			@(posedge sys_clk_i);
			if (avs_waitrequest_o === 1'b0)
				break;
		end
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (i == 20)
		begin
			miscompares++;
			end_of_test();
		end
	endtask : bus
	task cfg(input int en, input int rs, input int crm, input int pdc, input int lim);
		bus(1'b1, 4'h0, 32'(lim * 128 + pdc * 16 + crm * 4 + rs * 2 + en));
	endtask : cfg
	task st();
		chk("irq", {31'h0, (st_m & 2) != 0}, {31'h0, irq_o});
		bus(1'b0, 4'h4, 32'h0);
		chk("status", 32'(st_m), q);
		st_m = 0;
		bus(1'b0, 4'hc, 32'h0);
		chk("trim_reg", 32'(fc * 256 + trim_m), q);
	endtask : st
	task span(input int n, input int gv, input int pulses, input int good);
		int c;
		int k;
		int t;
		c = 0;
		t = gv * n;
		gap <= 16'(gv);
		run <= 1'b1;
		for (k = 0; k < pulses * gv + 50 && c < pulses; k++)
		begin
			@(posedge sys_clk_i);
			if (c == 1)
				chk("active", good, training_active_o);
			if (cmd_seen_i === 1'b1)
				c++;
		end
		run <= 1'b0;
		if (c < pulses)
		begin
			miscompares++;
			end_of_test();
		end
		for (k = 0; good != 0 && k < (pulses - 1) / n; k++)
		begin
			if (k == (pulses - 1) / n - 1)
			begin
				repeat (2) @(posedge sys_clk_i);
				chk("trim_hold", trim_m, trim_target_o);
			end
			if (t > E + W || t < E - W)
			begin
				fc = (fc < 127) ? fc + 1 : 127;
				st_m |= 4;
			end
			else
			begin
				fc = (fc > 0) ? fc - 1 : 0;
				if (t > E + D || t < E - D)
					st_m |= 2;
				trim_m += (t > E + D) ? -1 : (t < E - D) ? 1 : 0;
			end
			if (lim_m != 0 && fc >= lim_m)
				st_m |= 1;
		end
		repeat (20) @(posedge sys_clk_i);
		chk("trim", trim_m, trim_target_o);
	endtask : span
	initial
	begin
		void'($urandom(98));
		repeat (6) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		chk("trim_rst", 8'h80, trim_target_o);
		chk("wait_rst", 1'b1, avs_waitrequest_o);
		bus(1'b0, 4'h2, 32'h0);
		chk("unmapped", 32'h0, q);
		bus(1'b1, 4'hc, 32'h000000ff);
		bus(1'b1, 4'h8, 32'h00000002);
		bus(1'b0, 4'h8, 32'h0);
		chk("mask", 32'h00000002, q);
		for (r = 0; r < 9; r++)
		begin
			periodic_mode_i <= 1'(tb[r][0]);
			lim_m = tb[r][7];
			cfg(1, 0, tb[r][1], tb[r][2], lim_m);
			span(tb[r][3], tb[r][4] + int'($urandom % tb[r][5]), tb[r][6], 1);
			// Disable between spans so a stale open span never closes on a new run
			cfg(0, 0, tb[r][1], tb[r][2], lim_m);
			st();
		end
		periodic_mode_i <= 1'b0;
		lim_m = 0;
		for (r = 0; r < 4; r += 2)
		begin
			cfg(1, 0, r, 0, 0);
			span(1, 412, 3, 0);
			cfg(0, 0, 0, 0, 0);
			st_m |= 9;
			st();
		end
		cfg(1, 1, 3, 0, 0);
		span(1, 420, 2, 1);
		cfg(0, 1, 3, 0, 0);
		trim_m = 128;
		repeat (3) @(posedge sys_clk_i);
		chk("trim_reset", 8'h80, trim_target_o);
		st();
		end_of_test();
	end
endmodule : oscillator_training_test

//--- sim/otr_master_model.sv
// Periodic command source that stands in for the bus master.
// Assumes the bench sets the gap and starts and stops the run.
`timescale 1ns/1ps
module otr_master_model (
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire logic        run_i,
	input  wire logic [15:0] gap_i,
	output logic             cmd_o,
	output logic             blk_o
);
	logic [15:0] cnt_r;
	logic [4:0]  dly_r;
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			cnt_r <= 16'h0000;
			dly_r <= 5'h00;
		end
		else
		begin
			cnt_r <= (!run_i || cmd_o) ? 16'h0000 : cnt_r + 16'h0001;
			dly_r <= {dly_r[3:0], cmd_o};
		end
	end
	assign cmd_o = run_i && (cnt_r == gap_i - 16'h0001);
	// Blocking ends a fixed 5 cycles after each command
	assign blk_o = dly_r[4];
endmodule : otr_master_model
